// File: core/fifo_pkg.sv
// shared constants and types for the fifo device and its controller
package fifo_pkg;

  // ---------------------------------------------------------------
  // storage geometry
  // ---------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int ADDR_W = 15;
  localparam int PTR_W  = 16;
  localparam int OFFS_W = 16;
  localparam int DEPTH  = 32768;

  localparam logic [PTR_W-1:0]  DEPTH_COUNT = 16'h8000;
  localparam logic [PTR_W-1:0]  HALF_COUNT  = 16'h4000;
  localparam logic [ADDR_W-1:0] LAST_LOC    = 15'h7FFF;
  localparam logic [ADDR_W-1:0] FIRST_LOC   = 15'h0000;
  localparam logic [OFFS_W-1:0] OFFS_RESET  = 16'h007F;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 25;
  localparam int RECOVERY_NS = 40;
  localparam int RECOVERY_RAW = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVERY_CYC = (RECOVERY_RAW < 1) ? 1 : RECOVERY_RAW;

  // ---------------------------------------------------------------
  // controller register map (apb byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] WDATA_ADDR  = 8'h08;
  localparam logic [7:0] RDATA_ADDR  = 8'h0C;

  localparam int CTRL_RESET_BIT  = 0;
  localparam int CTRL_REWIND_BIT = 1;
  localparam int CTRL_LOAD_BIT   = 2;
  localparam int CTRL_READ_BIT   = 3;

  typedef enum logic [2:0] {
    C_IDLE, C_RESET, C_WRITE, C_READ, C_CAPT, C_REWIND, C_RECOVER
  } ctl_state_t;

endpackage : fifo_pkg

// File: core/fifo_link_if.sv
// link between the fifo device and its controlling logic
`timescale 1ns/1ps
interface fifo_link_if;
  import fifo_pkg::*;

  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] dout;
  logic              wr_en_n;
  logic              rd_en_n;
  logic              offset_load_n;
  logic              rewind;
  logic              fifo_reset_n;
  logic              full_n;
  logic              almost_full_n;
  logic              half_full_n;
  logic              almost_empty_n;
  logic              empty_n;

  modport dev (
    input  din, wr_en_n, rd_en_n, offset_load_n, rewind, fifo_reset_n,
    output dout, full_n, almost_full_n, half_full_n, almost_empty_n,
           empty_n
  );

  modport ctl (
    output din, wr_en_n, rd_en_n, offset_load_n, rewind, fifo_reset_n,
    input  dout, full_n, almost_full_n, half_full_n, almost_empty_n,
           empty_n
  );
endinterface : fifo_link_if

// File: core/fifo_flag_decode.sv
// occupancy to active-low status flag decode
`timescale 1ns/1ps
module fifo_flag_decode
  import fifo_pkg::*;
(
  // occupancy and thresholds
  input  wire logic [PTR_W-1:0]  count,
  input  wire logic [OFFS_W-1:0] empty_offs,
  input  wire logic [OFFS_W-1:0] full_offs,
  // flags, low when true
  output logic                   full_n,
  output logic                   almost_full_n,
  output logic                   half_full_n,
  output logic                   almost_empty_n,
  output logic                   empty_n
);

  logic [PTR_W:0] count_plus_m;

  // widened by one bit: an offset larger than the depth must not wrap
  assign count_plus_m = {1'b0, count} + {1'b0, full_offs};

  always_comb begin
    empty_n        = (count != '0);
    almost_empty_n = (count > empty_offs);
    half_full_n    = !(count > HALF_COUNT);
    almost_full_n  = !(count_plus_m >= {1'b0, DEPTH_COUNT});
    full_n         = (count != DEPTH_COUNT);
  end

endmodule : fifo_flag_decode

// File: core/fifo_device.sv
// fifo device end: storage, pointers, flags, offsets, rewind, cascade
`timescale 1ns/1ps
module fifo_device
  import fifo_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // link to the controlling logic
  fifo_link_if.dev  LINK,
  // cascade configuration and ring
  input  wire logic DEPTH_MODE,
  input  wire logic FIRST_DEVICE_SELECT_N,
  input  wire logic WRITE_CASCADE_IN_N,
  input  wire logic READ_CASCADE_IN_N,
  output logic      WRITE_CASCADE_OUT_N,
  output logic      READ_CASCADE_OUT_N
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]  wr_ptr_ff;
  logic [PTR_W-1:0]  rd_ptr_ff;
  logic [PTR_W-1:0]  nxt_wr_ptr;
  logic [PTR_W-1:0]  nxt_rd_ptr;
  logic [PTR_W-1:0]  nxt_count;
  logic [OFFS_W-1:0] empty_offs_ff;
  logic [OFFS_W-1:0] full_offs_ff;
  logic              offs_wsel_ff;
  logic              offs_rsel_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              started_ff;
  logic              wr_tok_ff;
  logic              rd_tok_ff;
  logic              wxo_n_ff;
  logic              rxo_n_ff;
  logic              full_n_ff;
  logic              almost_full_n_ff;
  logic              half_full_n_ff;
  logic              almost_empty_n_ff;
  logic              empty_n_ff;
  // full, almost full, half full, almost empty, empty; low when true
  logic [4:0]        flags_n_c;
  logic              clear;
  logic              wr_ok;
  logic              rd_ok;
  logic              offs_wr;
  logic              offs_rd;
  logic              rewinding;
  logic              first_dev;

  // ---------------------------------------------------------------
  // qualified operations
  // ---------------------------------------------------------------
  // fifo_reset is synchronous: strap sampling and pointer clear share an edge
  assign clear     = !LINK.fifo_reset_n || !started_ff;
  assign first_dev = !FIRST_DEVICE_SELECT_N;
  // data moves only with the token, which a stand-alone device always holds
  assign wr_ok = LINK.fifo_reset_n && !LINK.wr_en_n &&
                 LINK.offset_load_n && full_n_ff && wr_tok_ff;
  assign rd_ok = LINK.fifo_reset_n && !LINK.rd_en_n &&
                 LINK.offset_load_n && empty_n_ff && rd_tok_ff;
  assign offs_wr = LINK.fifo_reset_n && !LINK.offset_load_n &&
                   !LINK.wr_en_n;
  assign offs_rd = LINK.fifo_reset_n && !LINK.offset_load_n &&
                   !LINK.rd_en_n;
  assign rewinding = LINK.fifo_reset_n && LINK.rewind &&
                     !DEPTH_MODE;

  // ---------------------------------------------------------------
  // pointers
  // ---------------------------------------------------------------
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (clear) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
    end else begin
      // a rewind touches the read side only
      if (wr_ok) begin
        nxt_wr_ptr = wr_ptr_ff + 16'h0001;
      end
      if (rewinding) begin
        nxt_rd_ptr = '0;
      end else if (rd_ok) begin
        nxt_rd_ptr = rd_ptr_ff + 16'h0001;
      end
    end
  end
  // wrap arithmetic on the extra pointer bit gives 0..depth
  assign nxt_count = nxt_wr_ptr - nxt_rd_ptr;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // no reset on the array: a rewind or fifo reset keeps the words
  always_ff @(posedge CLK) begin
    if (wr_ok) begin
      mem[wr_ptr_ff[ADDR_W-1:0]] <= LINK.din;
    end
  end

  // ---------------------------------------------------------------
  // offset registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      empty_offs_ff <= OFFS_RESET;
      full_offs_ff  <= OFFS_RESET;
      offs_wsel_ff  <= 1'b0;
    end else if (!LINK.fifo_reset_n) begin
      empty_offs_ff <= OFFS_RESET;
      full_offs_ff  <= OFFS_RESET;
      offs_wsel_ff  <= 1'b0;
    end else if (offs_wr) begin
      if (offs_wsel_ff) begin
        full_offs_ff <= LINK.din[OFFS_W-1:0];
      end else begin
        empty_offs_ff <= LINK.din[OFFS_W-1:0];
      end
      offs_wsel_ff <= !offs_wsel_ff;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      offs_rsel_ff <= 1'b0;
    end else if (!LINK.fifo_reset_n) begin
      offs_rsel_ff <= 1'b0;
    end else if (offs_rd) begin
      offs_rsel_ff <= !offs_rsel_ff;
    end
  end

  // ---------------------------------------------------------------
  // output register
  // ---------------------------------------------------------------
  // a read on an empty fifo keeps the last word on the outputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dout_ff <= '0;
    end else if (!LINK.fifo_reset_n) begin
      dout_ff <= '0;
    end else if (offs_rd) begin
      dout_ff <= offs_rsel_ff ? {2'b00, full_offs_ff}
                              : {2'b00, empty_offs_ff};
    end else if (rd_ok) begin
      dout_ff <= mem[rd_ptr_ff[ADDR_W-1:0]];
    end
  end

  assign LINK.dout = dout_ff;
  // ---------------------------------------------------------------
  // depth cascade tokens
  // ---------------------------------------------------------------
  // the strap is only sampled by a clocked process after release
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_tok_ff <= 1'b0;
      wxo_n_ff  <= 1'b1;
    end else if (clear) begin
      wr_tok_ff <= first_dev || !DEPTH_MODE;
      wxo_n_ff  <= 1'b1;
    end else if (DEPTH_MODE && wr_ok &&
                 wr_ptr_ff[ADDR_W-1:0] == LAST_LOC) begin
      wr_tok_ff <= 1'b0;
      wxo_n_ff  <= 1'b0;
    end else begin
      wr_tok_ff <= wr_tok_ff || !WRITE_CASCADE_IN_N;
      wxo_n_ff  <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_tok_ff <= 1'b0;
      rxo_n_ff  <= 1'b1;
    end else if (clear) begin
      rd_tok_ff <= first_dev || !DEPTH_MODE;
      rxo_n_ff  <= 1'b1;
    end else if (DEPTH_MODE && rd_ok &&
                 rd_ptr_ff[ADDR_W-1:0] == LAST_LOC) begin
      rd_tok_ff <= 1'b0;
      rxo_n_ff  <= 1'b0;
    end else begin
      rd_tok_ff <= rd_tok_ff || !READ_CASCADE_IN_N;
      rxo_n_ff  <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  fifo_flag_decode fifo_flag_decode_inst (
    .count          (nxt_count),
    .empty_offs     (empty_offs_ff),
    .full_offs      (full_offs_ff),
    .full_n         (flags_n_c[4]),
    .almost_full_n  (flags_n_c[3]),
    .half_full_n    (flags_n_c[2]),
    .almost_empty_n (flags_n_c[1]),
    .empty_n        (flags_n_c[0])
  );

  // taken from the next pointers, so flags match the same cycle's pointers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      {full_n_ff, almost_full_n_ff, half_full_n_ff, almost_empty_n_ff,
       empty_n_ff} <= 5'h1C;
    end else begin
      {full_n_ff, almost_full_n_ff, half_full_n_ff, almost_empty_n_ff,
       empty_n_ff} <= flags_n_c;
    end
  end

  assign LINK.full_n         = full_n_ff;
  assign LINK.almost_full_n  = almost_full_n_ff;
  assign LINK.almost_empty_n = almost_empty_n_ff;
  assign LINK.empty_n        = empty_n_ff;
  // in depth mode the half-full pin carries the write cascade pulse
  assign LINK.half_full_n    = DEPTH_MODE ? wxo_n_ff
                                          : half_full_n_ff;
  assign WRITE_CASCADE_OUT_N = wxo_n_ff;
  assign READ_CASCADE_OUT_N  = rxo_n_ff;

endmodule : fifo_device

// File: core/fifo_ctrl.sv
// controlling end: apb registers drive writes, reads, rewind, reset
`timescale 1ns/1ps
module fifo_ctrl
  import fifo_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // link to the fifo device
  fifo_link_if.ctl         LINK
);

  ctl_state_t        state_ff;
  ctl_state_t        nxt_state;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              load_mode_ff;
  logic              refused_ff;
  logic [PTR_W:0]    wr_cnt_ff;
  logic              read_seen_ff;
  logic [3:0]        rec_cnt_ff;
  logic              busy;
  logic              action;
  logic              mapped;
  logic              access;
  logic              rewind_ok;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign busy   = (state_ff != C_IDLE);
  assign action = PWRITE && (PADDR == CTRL_ADDR || PADDR == WDATA_ADDR);
  assign mapped = (PADDR == CTRL_ADDR) || (PADDR == STATUS_ADDR) ||
                  (PADDR == WDATA_ADDR) || (PADDR == RDATA_ADDR);
  // an order is stalled, not dropped, while one is in progress
  assign PREADY  = !(PSEL && PENABLE && action && busy);
  assign access  = PSEL && PENABLE && PREADY;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_comb begin
    PRDATA = 32'h00000000;
    if (PSEL && !PWRITE) begin
      unique case (PADDR)
        CTRL_ADDR:   PRDATA = {29'h0, load_mode_ff, 2'b00};
        STATUS_ADDR: PRDATA = {24'h0, busy, refused_ff, LINK.full_n,
                               LINK.almost_full_n, LINK.half_full_n,
                               LINK.almost_empty_n, LINK.empty_n,
                               load_mode_ff};
        RDATA_ADDR:  PRDATA = {14'h0, rdata_ff};
        default:     PRDATA = 32'h00000000;
      endcase
    end
  end

  // rewind allowed only within one depth of writes and after a read
  assign rewind_ok = (wr_cnt_ff <= {1'b0, DEPTH_COUNT}) &&
                     read_seen_ff;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      C_IDLE: begin
        if (access && PWRITE && PADDR == CTRL_ADDR) begin
          if (PWDATA[CTRL_RESET_BIT]) begin
            nxt_state = C_RESET;
          end else if (PWDATA[CTRL_REWIND_BIT] && rewind_ok) begin
            nxt_state = C_REWIND;
          end else if (PWDATA[CTRL_READ_BIT]) begin
            nxt_state = C_READ;
          end
        end else if (access && PWRITE && PADDR == WDATA_ADDR) begin
          nxt_state = C_WRITE;
        end
      end
      C_RESET:   nxt_state = C_IDLE;
      C_WRITE:   nxt_state = C_IDLE;
      C_READ:    nxt_state = C_CAPT;
      C_CAPT:    nxt_state = C_IDLE;
      C_REWIND:  nxt_state = C_RECOVER;
      C_RECOVER: begin
        if (rec_cnt_ff == 4'(RECOVERY_CYC - 1)) begin
          nxt_state = C_IDLE;
        end
      end
      default:   nxt_state = C_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= C_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rec_cnt_ff <= 4'h0;
    end else if (state_ff == C_RECOVER) begin
      rec_cnt_ff <= rec_cnt_ff + 4'h1;
    end else begin
      rec_cnt_ff <= 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wdata_ff     <= '0;
      load_mode_ff <= 1'b0;
      refused_ff   <= 1'b0;
    end else if (access && PWRITE) begin
      if (PADDR == WDATA_ADDR) begin
        wdata_ff <= PWDATA[DATA_W-1:0];
      end
      if (PADDR == CTRL_ADDR) begin
        load_mode_ff <= PWDATA[CTRL_LOAD_BIT];
        if (PWDATA[CTRL_REWIND_BIT] && !PWDATA[CTRL_RESET_BIT]) begin
          refused_ff <= !rewind_ok;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_ff <= '0;
    end else if (state_ff == C_CAPT) begin
      rdata_ff <= LINK.dout;
    end
  end

  // history since the last fifo reset, for the rewind precondition
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_cnt_ff    <= '0;
      read_seen_ff <= 1'b0;
    end else if (state_ff == C_RESET) begin
      wr_cnt_ff    <= '0;
      read_seen_ff <= 1'b0;
    end else begin
      if (state_ff == C_WRITE && !load_mode_ff && LINK.full_n &&
          wr_cnt_ff != {1'b1, 16'hFFFF}) begin
        wr_cnt_ff <= wr_cnt_ff + 17'h00001;
      end
      if (state_ff == C_READ && !load_mode_ff && LINK.empty_n) begin
        read_seen_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // link drive
  // ---------------------------------------------------------------
  // enables stay off from the rewind pulse through recovery
  assign LINK.din           = wdata_ff;
  assign LINK.wr_en_n       = (state_ff != C_WRITE);
  assign LINK.rd_en_n       = (state_ff != C_READ);
  assign LINK.rewind        = (state_ff == C_REWIND);
  assign LINK.fifo_reset_n  = (state_ff != C_RESET);
  assign LINK.offset_load_n = !load_mode_ff;

endmodule : fifo_ctrl

// File: test/fifo_link_properties.sv
// assertions on the link between the two fifo ends
`timescale 1ns/1ps
module fifo_link_properties
  import fifo_pkg::*;
(
  // clock and reset
  input wire logic              CLK,
  input wire logic              NRST,
  // driven by the controller
  input wire logic              wr_en_n,
  input wire logic              rd_en_n,
  input wire logic              offset_load_n,
  input wire logic              rewind,
  input wire logic              fifo_reset_n,
  // driven by the device
  input wire logic [DATA_W-1:0] dout,
  input wire logic              full_n,
  input wire logic              half_full_n,
  input wire logic              almost_full_n,
  input wire logic              almost_empty_n,
  input wire logic              empty_n
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  ae_with_empty_a: assert property (!empty_n |-> !almost_empty_n)
    else $error("empty without almost empty");
  empty_not_full_a: assert property (!empty_n |->
    full_n && half_full_n) else $error("empty with full or half");
  reset_empties_a: assert property (!fifo_reset_n |->
    ##[1:2] !empty_n) else $error("fifo reset left data");
  rewind_quiet_a: assert property (rewind |->
    wr_en_n && rd_en_n ##1 wr_en_n && rd_en_n) else $error("busy in rewind");
  empty_read_a: assert property (!empty_n && !rd_en_n &&
    offset_load_n && fifo_reset_n |=> $stable(dout)) else $error("read empty");
  write_fills_a: assert property (!empty_n && !wr_en_n && rd_en_n &&
    offset_load_n && fifo_reset_n |=> empty_n) else $error("write lost");
  rewind_count_a: assert property (rewind |=> empty_n)
    else $error("rewind left fifo empty");
  offset_read_a: assert property (!offset_load_n && !rd_en_n |=>
    dout[17:16] == 2'b00) else $error("offset read upper bits set");
  rewind_c: cover property (rewind ##[2:20] !rd_en_n);
  ae_rise_c: cover property ($rose(almost_empty_n));
  af_fall_c: cover property ($fell(almost_full_n));
endmodule : fifo_link_properties

// File: test/sync_fifo_retransmit_flags_cascade_test.sv
// self-checking bench for the controller and device pair
`timescale 1ns/1ps
module sync_fifo_retransmit_flags_cascade_test
  import fifo_pkg::*;
  ;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, e, refd;
  logic        wco_n, rco_n, dmode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [17:0] mem[$];
  int          mismatches, checks_done, rp, en, fm;
  fifo_link_if link ();
  fifo_ctrl fifo_ctrl_inst (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  // a ring of one: the cascade outputs feed back to the inputs
  fifo_device fifo_device_inst (.CLK(clk), .NRST(nrst), .LINK(link),
    .DEPTH_MODE(dmode), .FIRST_DEVICE_SELECT_N(1'b0),
    .WRITE_CASCADE_IN_N(wco_n), .READ_CASCADE_IN_N(rco_n),
    .WRITE_CASCADE_OUT_N(wco_n), .READ_CASCADE_OUT_N(rco_n));
  fifo_link_properties fifo_link_properties_inst (.CLK(clk), .NRST(nrst),
    .wr_en_n(link.wr_en_n), .rd_en_n(link.rd_en_n), .rewind(link.rewind),
    .offset_load_n(link.offset_load_n), .fifo_reset_n(link.fifo_reset_n),
    .dout(link.dout), .full_n(link.full_n), .empty_n(link.empty_n),
    .almost_full_n(link.almost_full_n), .half_full_n(link.half_full_n),
    .almost_empty_n(link.almost_empty_n));
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] stat(input int c);
    stat = {24'h0, 1'b0, refd, c != DEPTH, c < DEPTH - fm, c <= DEPTH / 2,
            c > en, c != 0, 1'b0};
  endfunction : stat
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic give_up;
    mismatches++;
    final_report();
  endtask : give_up
  task automatic chk(input string n, input logic [31:0] s, x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // called just after a rising edge; pready is read at the edge itself,
  // before any flop moves, and one idle edge follows each transfer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (pready !== 1'b1) give_up();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic ctl(input logic [31:0] d);
    int k;
    apb(1'b1, CTRL_ADDR, d);
    k = 0;
    do begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      k++;
    end while (r[7] !== 1'b0 && k < 20);
    if (r[7] !== 1'b0) give_up();
  endtask : ctl
  task automatic sts;
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", r, stat(mem.size() - rp));
    chk("ring", {30'h0, wco_n, rco_n}, 32'h3);
  endtask : sts
  task automatic rpush;
    seed = xs(seed);
    apb(1'b1, WDATA_ADDR, {14'h0, seed[17:0]});
    ctl(32'h0);
    mem.push_back(seed[17:0]);
    sts();
  endtask : rpush
  task automatic pop;
    ctl(32'h8);
    apb(1'b0, RDATA_ADDR, 32'h0);
    chk("word", r, {14'h0, mem[rp]});
    rp++;
    sts();
  endtask : pop
  task automatic offs(input int x, y);
    ctl(32'h4);
    ctl(32'hC);
    apb(1'b0, RDATA_ADDR, 32'h0);
    chk("empty offset", r, x);
    ctl(32'hC);
    apb(1'b0, RDATA_ADDR, 32'h0);
    chk("full offset", r, y);
    ctl(32'h0);
  endtask : offs
  // ----------
  // sequence
  // ----------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, refd, dmode} = '0;
    {mismatches, checks_done, rp} = '0;
    seed = 32'hF9E4;
    en = 127;
    fm = 127;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    sts();
    apb(1'b0, 8'h10, 32'hFFFFFFFF);
    chk("unmapped", {r[30:0], e}, 32'h1);
    offs(127, 127);
    en = 2;
    fm = 32765;
    ctl(32'h4);
    apb(1'b1, WDATA_ADDR, 32'h2);
    apb(1'b1, WDATA_ADDR, 32'h7FFD);
    ctl(32'h0);
    offs(en, fm);
    repeat (5) rpush();
    repeat (2) pop();
    ctl(32'h2);
    rp = 0;
    sts();
    rpush();
    repeat (6) pop();
    ctl(32'h8);
    apb(1'b0, RDATA_ADDR, 32'h0);
    chk("empty read", r, {14'h0, mem[5]});
    ctl(32'h2);
    rp = 0;
    repeat (6) pop();
    ctl(32'h1);
    mem.delete();
    {rp, en, fm} = {32'd0, 32'd127, 32'd127};
    sts();
    offs(127, 127);
    refd = 1'b1;
    ctl(32'h2);
    sts();
    // depth cascade strap: a rewind order must leave the read pointer
    dmode <= 1'b1;
    ctl(32'h1);
    repeat (2) rpush();
    pop();
    refd = 1'b0;
    ctl(32'h2);
    pop();
    final_report();
  end
endmodule : sync_fifo_retransmit_flags_cascade_test
